// File: rtl/ext_irq_defs.svh
`ifndef EXT_IRQ_DEFS_SVH
`define EXT_IRQ_DEFS_SVH

// Register indices; byte address is four times the index
`define IDX_CTRL 8'h00
`define IDX_STATUS 8'h01
`define IDX_NMI_CONTROL 8'h02
`define IDX_NMI_FLAG 8'h03
`define IDX_EVENT_CONTROL 8'h04
`define IDX_ENABLE_CLEAR 8'h08
`define IDX_ENABLE_SET 8'h0C
`define IDX_IRQSTAT 8'h20
`define IDX_IRQMASK 8'h21

// Field positions
`define CTRL_SOFT_RESET 0
`define CTRL_ENABLE 1
`define STATUS_BUSY 7
`define NMI_CFG_MSB 3
`define NONMASKABLE_FLAG_BIT 0
`define IRQ_NMI 0
`define IRQ_RST 1
`define IRQ_BITS 2

// Reset values
`define RST_WORD 32'h0000_0000
`define RST_NMICFG 4'h0

// Trigger codes
`define SENSE_NONE 3'h0
`define SENSE_RISE 3'h1
`define SENSE_FALL 3'h2
`define SENSE_BOTH 3'h3
`define SENSE_HIGH 3'h4
`define SENSE_LOW 3'h5

// Timing
`define PERIPH_DIV_DEFAULT 4
`define SYNC_TICKS_DEFAULT 2

`endif

// File: rtl/ext_irq_pkg.sv
package ext_irq_pkg;

	typedef struct packed {
		logic filter_on;
		logic [2:0] trigger;
	} nmi_cfg_t;

	typedef enum logic [1:0] {
		SYNC_IDLE = 2'b01,
		SYNC_RUN = 2'b10
	} sync_state_t;

endpackage

// File: rtl/pin_sync3.sv
`timescale 1ns/1ps
module pin_sync3 #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Pins in, settled levels out
	input wire logic [WIDTH-1:0] pin,
	output logic [WIDTH-1:0] level
);
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			logic s1;
			logic s2;
			logic s3;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					s1 <= 1'b0;
					s2 <= 1'b0;
					s3 <= 1'b0;
					level[i] <= 1'b0;
				end else begin
					s1 <= pin[i];
					s2 <= s1;
					s3 <= s2;
					// Only a level seen by two stages in a row counts
					if (s2 == s3) begin
						level[i] <= s2;
					end
				end
			end
		end
	endgenerate
endmodule // pin_sync3

// File: rtl/nmi_detect.sv
`timescale 1ns/1ps
`include "ext_irq_defs.svh"
module nmi_detect (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Peripheral rate enable
	input wire logic tick,
	// Settled pin level and configuration
	input wire logic pin_level,
	input ext_irq_pkg::nmi_cfg_t cfg,
	// Detection pulse
	output logic hit
);
	logic [2:0] samples;
	logic level_prev;
	wire majority = (samples[0] & samples[1]) | (samples[0] & samples[2]) |
		(samples[1] & samples[2]);
	wire level_now = cfg.filter_on ? majority : pin_level; // see [R6] see [R13]
	wire match = (cfg.trigger == `SENSE_RISE) ? (level_now & ~level_prev) :
		(cfg.trigger == `SENSE_FALL) ? (~level_now & level_prev) :
		(cfg.trigger == `SENSE_BOTH) ? (level_now ^ level_prev) :
		(cfg.trigger == `SENSE_HIGH) ? level_now :
		(cfg.trigger == `SENSE_LOW) ? ~level_now : 1'b0; // see [R7]

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			samples <= 3'h0;
			level_prev <= 1'b0;
			hit <= 1'b0;
		end else begin
			hit <= tick & match;
			if (tick) begin
				samples <= {samples[1:0], pin_level};
				level_prev <= level_now;
			end
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_bypass_high;
		tick && !cfg.filter_on && cfg.trigger == `SENSE_HIGH && pin_level |=> hit;
	endproperty
	a_bypass_high: assert property (p_bypass_high) else $error("bypass high missed"); // see [R6]

	property p_filter_vote;
		tick && cfg.filter_on && cfg.trigger == `SENSE_HIGH && $countones(samples) >= 2
			|=> hit;
	endproperty
	a_filter_vote: assert property (p_filter_vote) else $error("majority vote missed"); // see [R13]

	property p_reserved_quiet;
		cfg.trigger > `SENSE_LOW || cfg.trigger == `SENSE_NONE |=> !hit;
	endproperty
	a_reserved_quiet: assert property (p_reserved_quiet) else $error("hit on no-detect"); // see [R7]

	property p_rise;
		tick && cfg.trigger == `SENSE_RISE && level_now && !level_prev |=> hit;
	endproperty
	a_rise: assert property (p_rise) else $error("rising edge missed"); // see [R7]
endmodule // nmi_detect

// File: rtl/ext_irq_unit.sv
`timescale 1ns/1ps
`include "ext_irq_defs.svh"
// Notes on behaviour
// [R1] Writing soft reset one restores every register and disables the unit; zero does nothing. The code leaves IRQSTAT with its IRQ_RST bit set.
// [R2] A write setting soft reset discards all other bits of that write.
// [R3] Reset ends after sync; soft reset bit and busy clear together.
// [R4] Soft reset bit reads one while reset pending, zero otherwise.
// [R5] Busy at status bit 7 rises when sync starts, falls when done.
// [R6] Filter bit 3 of NMI control register enables the pin filter; zero bypasses.
// [R7] Trigger field: none, rise, fall, both, high, low; 6 and 7 reserved.
// [R8] Pin matching trigger sets the flag, which raises the request.
// [R9] Writing one clears the flag; writing zero leaves it.
// [R10] Per line enable bit lets a line detection produce an event output.
// [R11] Enable clear: one clears line enable, zero nothing, read shows enables.
// [R12] Control write during busy stalls the bus until sync done, then completes.
// [R13] Filtered level is the majority of three peripheral rate samples.
module ext_irq_unit #(
	parameter int LINES = 16,
	parameter int PERIPH_DIV = `PERIPH_DIV_DEFAULT,
	parameter int SYNC_TICKS = `SYNC_TICKS_DEFAULT
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins
	input wire logic nmi_pin,
	input wire logic [LINES-1:0] external_line,
	// Requests and events
	output logic nmi_request,
	output logic [LINES-1:0] event_out,
	output logic [LINES-1:0] line_irq_enable,
	output logic unit_enabled,
	output logic irq
);
	localparam logic [7:0] DIV_LAST = 8'(PERIPH_DIV - 1);
	localparam logic [7:0] SYNC_LAST = 8'(SYNC_TICKS - 1);
	localparam int STALL_MAX = SYNC_TICKS * PERIPH_DIV + 2;

	ext_irq_pkg::sync_state_t sync_state;
	ext_irq_pkg::nmi_cfg_t nmi_cfg;
	logic [7:0] div_cnt;
	logic [7:0] sync_cnt;
	logic soft_reset_bit;
	logic nonmaskable_flag_reg;
	logic [LINES-1:0] pin_event_out_enable;
	logic [`IRQ_BITS-1:0] irq_status;
	logic [`IRQ_BITS-1:0] irq_mask;
	logic [LINES-1:0] line_level;
	logic [LINES-1:0] line_prev;
	logic nmi_level;
	logic nmi_hit;

	// Peripheral rate enable
	wire periph_tick = (div_cnt == DIV_LAST);
	wire domain_sync_pending = (sync_state == ext_irq_pkg::SYNC_RUN);
	wire sync_done = domain_sync_pending & periph_tick & (sync_cnt == SYNC_LAST);
	wire soft_clear = sync_done & soft_reset_bit;

	// Address decode
	wire [7:0] reg_idx = paddr[9:2];
	wire aligned = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
	wire ctrl_hit = aligned && (reg_idx == `IDX_CTRL);
	wire status_hit = aligned && (reg_idx == `IDX_STATUS);
	wire nmicfg_hit = aligned && (reg_idx == `IDX_NMI_CONTROL);
	wire flag_hit = aligned && (reg_idx == `IDX_NMI_FLAG);
	wire evcfg_hit = aligned && (reg_idx == `IDX_EVENT_CONTROL);
	wire enclr_hit = aligned && (reg_idx == `IDX_ENABLE_CLEAR);
	wire enset_hit = aligned && (reg_idx == `IDX_ENABLE_SET);
	wire stat_hit = aligned && (reg_idx == `IDX_IRQSTAT);
	wire mask_hit = aligned && (reg_idx == `IDX_IRQMASK);
	wire mapped = ctrl_hit | status_hit | nmicfg_hit | flag_hit | evcfg_hit |
		enclr_hit | enset_hit | stat_hit | mask_hit;

	// Only the control register crosses domains, so only it stalls
	wire stall = psel & penable & pwrite & ctrl_hit & domain_sync_pending; // see [R12]
	assign pready = ~stall;
	assign pslverr = psel & penable & ~mapped;
	wire wr_fire = psel & penable & pwrite & pready & mapped;
	wire [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	wire [31:0] wbits = pwdata & wmask;
	wire ctrl_wr = wr_fire & ctrl_hit & pstrb[0];
	wire soft_req = ctrl_wr & pwdata[`CTRL_SOFT_RESET];
	wire flag_clr = wr_fire & flag_hit & wbits[`NONMASKABLE_FLAG_BIT]; // see [R9]

	// Line detection: settled rising edge
	wire [LINES-1:0] line_rise = line_level & ~line_prev;

	// Read mux
	wire [31:0] rd_ctrl = {30'h0, unit_enabled, soft_reset_bit}; // see [R4]
	wire [31:0] rd_status = {24'h0, domain_sync_pending, 7'h00}; // see [R5]
	wire [31:0] rd_nmicfg = {28'h0, nmi_cfg};
	wire [31:0] rd_flag = {31'h0, nonmaskable_flag_reg};
	wire [31:0] rd_ev = {{(32 - LINES){1'b0}}, pin_event_out_enable};
	wire [31:0] rd_en = {{(32 - LINES){1'b0}}, line_irq_enable}; // see [R11]
	wire [31:0] rd_stat = {{(32 - `IRQ_BITS){1'b0}}, irq_status};
	wire [31:0] rd_mask = {{(32 - `IRQ_BITS){1'b0}}, irq_mask};
	wire [31:0] rd_word = ctrl_hit ? rd_ctrl :
		status_hit ? rd_status :
		nmicfg_hit ? rd_nmicfg :
		flag_hit ? rd_flag :
		evcfg_hit ? rd_ev :
		(enclr_hit | enset_hit) ? rd_en :
		stat_hit ? rd_stat :
		mask_hit ? rd_mask : `RST_WORD;

	assign nmi_request = nonmaskable_flag_reg; // see [R8]
	assign irq = |(irq_status & irq_mask);

	pin_sync3 #(
		.WIDTH(LINES + 1)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.pin({nmi_pin, external_line}),
		.level({nmi_level, line_level})
	);

	nmi_detect u_nmi (
		.pclk(pclk),
		.presetn(presetn),
		.tick(periph_tick),
		.pin_level(nmi_level),
		.cfg(nmi_cfg),
		.hit(nmi_hit)
	);

	// Divider and read data capture
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_cnt <= 8'h00;
			prdata <= `RST_WORD;
		end else begin
			div_cnt <= periph_tick ? 8'h00 : div_cnt + 8'h01;
			if (psel) begin
				prdata <= rd_word;
			end
		end
	end

	// Synchronisation sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_state <= ext_irq_pkg::SYNC_IDLE;
			sync_cnt <= 8'h00;
			soft_reset_bit <= 1'b0;
			unit_enabled <= 1'b0;
		end else begin
			case (sync_state)
				ext_irq_pkg::SYNC_IDLE: begin
					if (ctrl_wr) begin
						sync_state <= ext_irq_pkg::SYNC_RUN; // see [R5]
						sync_cnt <= 8'h00;
						soft_reset_bit <= soft_req; // see [R1]
						if (!soft_req) begin
							unit_enabled <= pwdata[`CTRL_ENABLE]; // see [R2]
						end
					end
				end
				ext_irq_pkg::SYNC_RUN: begin
					if (sync_done) begin
						sync_state <= ext_irq_pkg::SYNC_IDLE; // see [R3]
						soft_reset_bit <= 1'b0;
						if (soft_reset_bit) begin
							unit_enabled <= 1'b0;
						end
					end else if (periph_tick) begin
						sync_cnt <= sync_cnt + 8'h01;
					end
				end
				default: begin
					sync_state <= ext_irq_pkg::SYNC_IDLE;
				end
			endcase
		end
	end

	// Configuration registers; soft reset outranks any write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_cfg <= `RST_NMICFG;
			pin_event_out_enable <= '0;
			line_irq_enable <= '0;
			irq_mask <= '0;
		end else if (soft_clear) begin
			nmi_cfg <= `RST_NMICFG; // see [R1]
			pin_event_out_enable <= '0;
			line_irq_enable <= '0;
			irq_mask <= '0;
		end else if (wr_fire) begin
			if (nmicfg_hit && pstrb[0]) begin
				nmi_cfg <= pwdata[`NMI_CFG_MSB:0]; // see [R6] see [R7]
			end
			if (evcfg_hit) begin
				pin_event_out_enable <= (pin_event_out_enable & ~wmask[LINES-1:0]) |
					wbits[LINES-1:0];
			end
			if (enclr_hit) begin
				line_irq_enable <= line_irq_enable & ~wbits[LINES-1:0]; // see [R11]
			end
			if (enset_hit) begin
				line_irq_enable <= line_irq_enable | wbits[LINES-1:0];
			end
			if (mask_hit) begin
				irq_mask <= (irq_mask & ~wmask[`IRQ_BITS-1:0]) | wbits[`IRQ_BITS-1:0];
			end
		end
	end

	// Flags: a new event beats a clear in the same cycle
	wire [`IRQ_BITS-1:0] irq_set = {soft_clear, nmi_hit};
	wire [`IRQ_BITS-1:0] irq_clr = (wr_fire & stat_hit) ? wbits[`IRQ_BITS-1:0] : '0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nonmaskable_flag_reg <= 1'b0;
			irq_status <= '0;
		end else begin
			if (nmi_hit) begin
				nonmaskable_flag_reg <= 1'b1; // see [R8]
			end else if (flag_clr || soft_clear) begin
				nonmaskable_flag_reg <= 1'b0; // see [R9]
			end
			irq_status <= ((soft_clear ? '0 : irq_status) & ~irq_clr) | irq_set;
		end
	end

	// Line events, gated per line
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_prev <= '0;
			event_out <= '0;
		end else begin
			line_prev <= line_level;
			event_out <= line_rise & pin_event_out_enable & {LINES{unit_enabled}}; // see [R10]
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_reset_req;
		ctrl_wr && pwdata[`CTRL_SOFT_RESET];
	endsequence

	sequence s_reset_end;
		soft_clear;
	endsequence

	property p_soft_restore;
		s_reset_end |=> !unit_enabled && nmi_cfg == `RST_NMICFG &&
			pin_event_out_enable == '0 && line_irq_enable == '0;
	endproperty
	a_soft_restore: assert property (p_soft_restore) else $error("soft reset left state"); // see [R1]

	property p_discard_others;
		s_reset_req |=> $stable(unit_enabled);
	endproperty
	a_discard_others: assert property (p_discard_others) else $error("enable taken"); // see [R2]

	property p_clear_together;
		$fell(soft_reset_bit) |-> $fell(domain_sync_pending);
	endproperty
	a_clear_together: assert property (p_clear_together) else $error("bits not cleared together"); // see [R3]

	property p_reads_pending;
		s_reset_req |=> soft_reset_bit throughout (##[0:STALL_MAX] s_reset_end);
	endproperty
	a_reads_pending: assert property (p_reads_pending) else $error("reset bit dropped early"); // see [R4]

	property p_busy_span;
		ctrl_wr |=> domain_sync_pending[*2] ##[0:STALL_MAX] !domain_sync_pending;
	endproperty
	a_busy_span: assert property (p_busy_span) else $error("busy span wrong"); // see [R5]

	property p_stall;
		psel && penable && pwrite && ctrl_hit && domain_sync_pending |-> !pready
			##[1:STALL_MAX] pready;
	endproperty
	a_stall: assert property (p_stall) else $error("control write not stalled"); // see [R12]

	property p_flag_set;
		nmi_hit |=> nonmaskable_flag_reg && nmi_request;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("flag not set"); // see [R8]

	property p_flag_clear;
		flag_clr && !nmi_hit |=> !nonmaskable_flag_reg;
	endproperty
	a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared"); // see [R9]

	property p_flag_hold;
		nonmaskable_flag_reg && !flag_clr && !soft_clear |=> nonmaskable_flag_reg;
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("flag lost"); // see [R9]

	property p_event_gate;
		(event_out & ~$past(pin_event_out_enable)) == '0;
	endproperty
	a_event_gate: assert property (p_event_gate) else $error("event from disabled line"); // see [R10]

	property p_enable_clear;
		wr_fire && enclr_hit |=> (line_irq_enable & $past(wbits[LINES-1:0])) == '0;
	endproperty
	a_enable_clear: assert property (p_enable_clear) else $error("enable not cleared"); // see [R11]
endmodule // ext_irq_unit

// File: tb/pin_model.sv
`timescale 1ns/1ps
module pin_model (
	// Clock
	input wire logic pclk,
	// Levels the bench asks for
	input wire logic nmi_want,
	input wire logic [15:0] lines_want,
	// Pins toward the unit
	output logic nmi_pin,
	output logic [15:0] external_line
);
	// Pins move just after an edge; their timing relative to the tick is still arbitrary
	// Unknown before the first edge is harmless: the synchronisers are held in reset
	always @(posedge pclk) begin
		nmi_pin <= nmi_want;
		external_line <= lines_want;
	end
endmodule // pin_model

// File: tb/tb_ext_irq_unit.sv
`timescale 1ns/1ps
`include "ext_irq_defs.svh"
module tb_ext_irq_unit;
	logic pclk;
	logic presetn;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic nmi_want;
	logic [15:0] lines_want;
	logic nmi_pin;
	logic [15:0] external_line;
	logic nmi_request;
	logic [15:0] event_out;
	logic [15:0] line_irq_enable;
	logic unit_enabled;
	logic irq;
	int n_errors;
	int checked;
	int waits;
	logic [31:0] rd;
	logic err;
	logic hit;
	logic [15:0] seen_ev;
	// Last entry is a reserved code, which must stay silent
	logic [7:0] codes [8] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h09, 8'h00, 8'h06};
	logic start_lvl [8] = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
	logic want_hit [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
	logic [7:0] rst_idx [6] = '{`IDX_CTRL, `IDX_STATUS, `IDX_NMI_CONTROL, `IDX_NMI_FLAG,
		`IDX_EVENT_CONTROL, `IDX_ENABLE_CLEAR};

	// Longer sync so a pending reset is still visible to a following read
	ext_irq_unit #(.LINES(16), .PERIPH_DIV(4), .SYNC_TICKS(4)) u_ext_irq_unit (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .nmi_pin(nmi_pin), .external_line(external_line),
		.nmi_request(nmi_request), .event_out(event_out), .line_irq_enable(line_irq_enable),
		.unit_enabled(unit_enabled), .irq(irq)
	);

	pin_model u_pin_model (.pclk(pclk), .nmi_want(nmi_want), .lines_want(lines_want),
		.nmi_pin(nmi_pin), .external_line(external_line));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task print_verdict;
		$display("comparisons %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	task check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		for (waits = 0; waits < 100; waits++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (waits == 100) begin
			n_errors++;
			print_verdict;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task rdchk(input logic [7:0] idx, input logic [31:0] exp, input string what);
		apb(1'b0, idx, 32'h0000_0000);
		check(rd, exp, what);
	endtask

	task wait_nmi;
		hit = 1'b0;
		for (int k = 0; k < 60 && hit !== 1'b1; k++) begin
			@(posedge pclk);
			hit = nmi_request;
		end
	endtask

	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, nmi_want} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		lines_want = 16'h0000;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rst_idx[i]) rdchk(rst_idx[i], 32'h0000_0000, "reset value");
		apb(1'b0, 8'h40, 32'h0000_0000);
		check({31'h0, err}, 32'h0000_0001, "unmapped error");
		$display("test reset_and_map done");

		for (int i = 0; i < 8; i++) begin
			nmi_want <= start_lvl[i];
			apb(1'b1, `IDX_NMI_CONTROL, {24'h0, codes[i]});
			rdchk(`IDX_NMI_CONTROL, {24'h0, codes[i]}, "trigger config");
			repeat (40) @(posedge pclk);
			apb(1'b1, `IDX_NMI_FLAG, 32'h0000_0001);
			rdchk(`IDX_NMI_FLAG, 32'h0000_0000, "flag cleared");
			nmi_want <= ~start_lvl[i];
			wait_nmi;
			check({31'h0, hit}, {31'h0, want_hit[i]}, "nmi detect");
			apb(1'b1, `IDX_NMI_FLAG, 32'h0000_0000);
			rdchk(`IDX_NMI_FLAG, {31'h0, want_hit[i]}, "flag after zero");
			nmi_want <= start_lvl[i];
			repeat (40) @(posedge pclk);
			apb(1'b1, `IDX_NMI_FLAG, 32'h0000_0001);
		end
		for (int f = 0; f < 2; f++) begin
			apb(1'b1, `IDX_NMI_CONTROL, {28'h0, f[0], 3'h4});
			repeat (40) @(posedge pclk);
			apb(1'b1, `IDX_NMI_FLAG, 32'h0000_0001);
			// One tick wide pulse: only the majority filter rejects it
			@(posedge pclk);
			nmi_want <= 1'b1;
			repeat (4) @(posedge pclk);
			nmi_want <= 1'b0;
			repeat (40) @(posedge pclk);
			rdchk(`IDX_NMI_FLAG, {31'h0, ~f[0]}, "filter pulse");
			// A held level wins the vote with or without the filter
			nmi_want <= 1'b1;
			repeat (40) @(posedge pclk);
			nmi_want <= 1'b0;
			rdchk(`IDX_NMI_FLAG, 32'h0000_0001, "filter long level");
		end
		$display("test nmi_sense done");

		apb(1'b1, `IDX_NMI_CONTROL, 32'h0000_0000);
		apb(1'b1, `IDX_IRQMASK, 32'h0000_0000);
		check({31'h0, irq}, 32'h0000_0000, "irq masked");
		apb(1'b1, `IDX_IRQMASK, 32'h0000_0001);
		@(posedge pclk);
		check({31'h0, irq}, 32'h0000_0001, "irq unmasked");
		apb(1'b1, `IDX_IRQSTAT, 32'h0000_0001);
		@(posedge pclk);
		check({31'h0, irq}, 32'h0000_0000, "irq cleared");
		$display("test interrupt done");

		apb(1'b1, `IDX_ENABLE_SET, 32'h0000_FFFF);
		apb(1'b1, `IDX_ENABLE_CLEAR, 32'h0000_00F0);
		rdchk(`IDX_ENABLE_CLEAR, 32'h0000_FF0F, "enable clear");
		apb(1'b1, `IDX_ENABLE_CLEAR, 32'h0000_0000);
		rdchk(`IDX_ENABLE_CLEAR, 32'h0000_FF0F, "clear zero");
		check({16'h0, line_irq_enable}, 32'h0000_FF0F, "enable pins");
		apb(1'b1, `IDX_EVENT_CONTROL, 32'h0000_0005);
		apb(1'b1, `IDX_CTRL, 32'h0000_0002);
		repeat (20) @(posedge pclk);
		seen_ev = 16'h0000;
		lines_want <= 16'h0007;
		repeat (40) begin
			@(posedge pclk);
			seen_ev = seen_ev | event_out;
		end
		check({16'h0, seen_ev}, 32'h0000_0005, "event enables");
		lines_want <= 16'h0000;
		$display("test events done");

		// Enable zero rides along with the reset and must be ignored while it runs
		apb(1'b1, `IDX_CTRL, 32'h0000_0001);
		check({31'h0, unit_enabled}, 32'h0000_0001, "enable discarded");
		rdchk(`IDX_CTRL, 32'h0000_0003, "reset pending");
		rdchk(`IDX_STATUS, 32'h0000_0080, "busy set");
		for (int k = 0; k < 40 && rd !== 32'h0000_0000; k++) apb(1'b0, `IDX_STATUS, 32'h0);
		check(rd, 32'h0000_0000, "busy cleared");
		rdchk(`IDX_CTRL, 32'h0000_0000, "reset done");
		rdchk(`IDX_EVENT_CONTROL, 32'h0000_0000, "event control reset");
		rdchk(`IDX_ENABLE_CLEAR, 32'h0000_0000, "enables reset");
		check({31'h0, unit_enabled}, 32'h0000_0000, "unit disabled");
		rdchk(`IDX_IRQSTAT, 32'h0000_0002, "reset done status");
		apb(1'b1, `IDX_CTRL, 32'h0000_0002);
		apb(1'b1, `IDX_CTRL, 32'h0000_0000);
		check({31'h0, waits > 0}, 32'h0000_0001, "write stalled");
		rdchk(`IDX_CTRL, 32'h0000_0000, "stalled write landed");
		$display("test soft_reset done");
		print_verdict;
	end
endmodule // tb_ext_irq_unit
